// [hdl/cidh_top.v]
// Host interface logic of a caller id receiver: sleep control,
// demodulator select, 3-wire serial byte output, alert, interrupt.
// Assumes demodulated bits, carrier, tone and ring levels arrive
// synchronous to pclk from the analog and demodulator sections.
//
// What this block does
// - Sleep bit high holds the receive sequencer, host clock synchroniser and half bit timer in reset.
// - Ring detect path keeps running while sleep is set.
// - Demod select high enables FSK, low enables tone detector.
// - Bit clock driven in mode 0, taken from host in mode 1.
// - Mode 0 data pin follows demodulated bit stream.
// - Mode 1 shifts next stored bit on each host clock rise.
// - Mark is logic one, space is logic zero in both modes.
// - Mode 0 byte-ready pulses low at each 8-bit boundary.
// - Mode 1 byte-ready falls once a whole byte is stored.
// - Carrier-present low while FSK carrier is detected.
// - Interrupt low while ring, byte-ready or qualified alert active.
// - Qualified alert high after tone detected and guard time met.
// - Raw alert shows tone detection without guard time.
// - Internal timing derives from pclk, not the documented system clock.
// - Mode low selects mode 0, mode high selects mode 1.
// - Mode 0 emits 8 clock pulses per byte, rises mid bit.
// - Mode 1 shifts LSB first, ignores clocks after the MSB.
// - Mode 1 byte-ready rises on first host clock or half bit.
`timescale 1ns/1ps
`include "cidh_consts.vh"
module cidh_top #(
	parameter HALF_BIT_CYC = `CIDH_HALF_BIT_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        demod_bit,
	input  wire        demod_bit_mid,
	input  wire        demod_start,
	input  wire        carrier_det,
	input  wire        tone_det,
	input  wire        tone_guard_met,
	input  wire        ring_sense_in,
	input  wire        ring_hold_rc,
	input  wire        serial_bit_clock_i,
	output reg         serial_bit_clock_o,
	output reg         serial_bit_clock_oe_n,
	output reg         serial_data,
	output reg         byte_ready_n,
	output reg         carrier_present_n,
	output reg         alert_qualified,
	output reg         alert_raw,
	output reg         ring_detect_n,
	output reg         host_irq_n_o,
	output reg         host_irq_n_oe_n,
	output reg         sleep_out,
	output reg         demod_select
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_BITS = 2'h1;
	localparam [1:0] ST_HOLD = 2'h2;

	reg  [2:0]  ctrl_q;
	reg  [1:0]  st_q;
	reg  [3:0]  cnt_q;
	reg  [7:0]  shift_q;
	reg  [7:0]  hold_q;
	reg  [3:0]  out_cnt_q;
	reg         hclk_prev_q;
	reg         ring_q;
	wire        sleep;
	wire        mode1;
	wire        run;
	wire        hclk_s;
	wire        hclk_rise;
	wire        hb_run;
	wire        fsk_on;
	wire        apb_acc;
	wire        byte_load;
	reg  [31:0] rd_d;
	reg         ok_d;

	assign sleep = ctrl_q[`CIDH_CTRL_SLEEP];
	assign mode1 = (ctrl_q[`CIDH_CTRL_MODE] == `CIDH_MODE1);
	assign run = presetn & ~sleep;
	assign fsk_on = ctrl_q[`CIDH_CTRL_DEMOD] & carrier_det;
	assign apb_acc = psel & penable & ~pready;
	// Mode 1 byte enters the hold register on this edge
	assign byte_load = mode1 & fsk_on & (st_q == ST_BITS)
		& (cnt_q == 4'h8);
	// Rise of host clock seen only after the synchroniser
	assign hclk_rise = hclk_s & ~hclk_prev_q;

	// Host bit clock crosses into pclk before edge use
	cidh_sync u_hclk_sync (
		.pclk     (pclk),
		.presetn  (run),
		.async_in (serial_bit_clock_i),
		.sync_out (hclk_s)
	);

	// Half bit timer bounds byte-ready low time in mode 1
	cidh_half_bit #(
		.CYCLES (HALF_BIT_CYC)
	) u_half_bit (
		.pclk    (pclk),
		.presetn (run),
		.start   (byte_load),
		.cancel  (hclk_rise),
		.running (hb_run)
	);

	// APB read mux and address check
	always @* begin
		rd_d = 32'h00000000;
		ok_d = 1'b1;
		case (paddr)
		`CIDH_REG_CTRL: rd_d = {29'h0, ctrl_q};
		`CIDH_REG_STAT: rd_d = {25'h0, alert_raw, alert_qualified,
			ring_detect_n, carrier_present_n, byte_ready_n,
			host_irq_n_o, sleep};
		`CIDH_REG_DATA: rd_d = {24'h0, hold_q};
		default: ok_d = 1'b0;
		endcase
	end

	// APB slave: one wait state, write takes effect with pready
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CIDH_CTRL_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc & ~ok_d;
			if (apb_acc && !pwrite)
				prdata <= rd_d;
			if (apb_acc && pwrite && paddr == `CIDH_REG_CTRL)
				ctrl_q <= pwdata[2:0];
		end
	end

	// Ring path runs from bus reset only, unaffected by sleep
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_q <= 1'b0;
			ring_detect_n <= 1'b1;
		end else begin
			ring_q <= ring_sense_in | ~ring_hold_rc;
			ring_detect_n <= ~ring_q;
		end
	end

	// Receive and serial output sequencer, cleared by sleep
	always @(posedge pclk or negedge run) begin
		if (!run) begin
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			hold_q <= 8'h00;
			out_cnt_q <= 4'h8;
			hclk_prev_q <= 1'b0;
			serial_bit_clock_o <= 1'b1;
			serial_data <= 1'b1;
			byte_ready_n <= 1'b1;
		end else begin
			hclk_prev_q <= hclk_s;
			serial_bit_clock_o <= 1'b1;
			if (!mode1)
				byte_ready_n <= 1'b1;
			case (st_q)
			ST_IDLE: begin
				if (fsk_on && demod_start) begin
					st_q <= ST_BITS;
					cnt_q <= 4'h0;
				end
			end
			ST_BITS: begin
				if (!fsk_on) begin
					st_q <= ST_IDLE;
				end else if (cnt_q == 4'h8) begin
					st_q <= ST_HOLD;
					if (mode1) begin
						hold_q <= shift_q;
						out_cnt_q <= 4'h0;
						byte_ready_n <= 1'b0;
					end else begin
						byte_ready_n <= 1'b0;
					end
				end else if (demod_bit_mid) begin
					// Mark shifts in as 1, space as 0
					shift_q <= {demod_bit, shift_q[7:1]};
					cnt_q <= cnt_q + 4'h1;
					if (!mode1) begin
						serial_data <= demod_bit;
						serial_bit_clock_o <= 1'b0;
					end
				end
			end
			ST_HOLD: begin
				st_q <= ST_IDLE;
			end
			default: st_q <= ST_IDLE;
			endcase
			// Mode 0 clock falls for the cycle of each mid-bit strobe
			// and rises after; no pulses for start or stop bits.
			if (mode1) begin
				// A host rise on the loading edge would clobber the new byte
				if (hclk_rise && !byte_load && out_cnt_q != 4'h8) begin
					serial_data <= hold_q[out_cnt_q[2:0]];
					out_cnt_q <= out_cnt_q + 4'h1;
				end
				// Ready ends on first host edge or timer expiry
				if (!byte_ready_n && !hb_run && st_q != ST_BITS)
					byte_ready_n <= 1'b1;
				if (hclk_rise && !byte_load)
					byte_ready_n <= 1'b1;
			end else if (!fsk_on) begin
				serial_data <= 1'b1;
			end
		end
	end

	// Pin levels, alert, carrier and interrupt, registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_bit_clock_oe_n <= 1'b1;
			carrier_present_n <= 1'b1;
			alert_qualified <= 1'b0;
			alert_raw <= 1'b0;
			host_irq_n_o <= 1'b0;
			host_irq_n_oe_n <= 1'b1;
			sleep_out <= 1'b1;
			demod_select <= 1'b0;
		end else begin
			sleep_out <= sleep;
			demod_select <= ctrl_q[`CIDH_CTRL_DEMOD];
			serial_bit_clock_oe_n <= ~run | mode1;
			carrier_present_n <= ~(run & ctrl_q[`CIDH_CTRL_DEMOD]
				& carrier_det);
			// Tone detector only live with demodulator off
			alert_raw <= run & ~ctrl_q[`CIDH_CTRL_DEMOD]
				& tone_det;
			alert_qualified <= run & ~ctrl_q[`CIDH_CTRL_DEMOD]
				& tone_det & tone_guard_met;
			// Open drain: enable low pulls the line low
			host_irq_n_oe_n <= ~(~ring_detect_n | ~byte_ready_n
				| alert_qualified);
		end
	end

	// Timing uses pclk; the documented rate is kept for reference
	localparam SYS_HZ = `CIDH_SYSCLK_HZ;
endmodule

// [include/cidh_consts.vh]
// Constants of the caller id host interface logic.
// Assumes inclusion by bare name from the design files.
`ifndef CIDH_CONSTS_VH
`define CIDH_CONSTS_VH
// System clock rate in Hz, as documented for the receiver
`define CIDH_SYSCLK_HZ 3579545
// Bus clock rate in Hz
`define CIDH_PCLK_HZ 125000000
// Half a nominal bit time, in microseconds (1/2400 s)
`define CIDH_HALF_BIT_US 416
// Half bit time in pclk cycles, rounded down as a longest time
`define CIDH_HALF_BIT_CYC ((`CIDH_PCLK_HZ / 1000000) * `CIDH_HALF_BIT_US)
// Width of a received character
`define CIDH_BYTE_BITS 8
// Mode pin level for mode 0 and mode 1
`define CIDH_MODE0 1'b0
`define CIDH_MODE1 1'b1
// APB register byte offsets
`define CIDH_REG_CTRL 12'h000
`define CIDH_REG_STAT 12'h004
`define CIDH_REG_DATA 12'h008
// Control field positions
`define CIDH_CTRL_SLEEP 0
`define CIDH_CTRL_DEMOD 1
`define CIDH_CTRL_MODE 2
// Control reset value: sleep set, demodulator off, mode 0
`define CIDH_CTRL_RST 3'h1
`endif

// [hdl/cidh_sync.v]
// Two flip-flop synchroniser for one level input.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
module cidh_sync (
	input  wire pclk,
	input  wire presetn,
	input  wire async_in,
	output wire sync_out
);
	reg meta_q;
	reg sync_q;

	// First stage feeds only the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// [hdl/cidh_half_bit.v]
// Down counter that times half a nominal bit after a start pulse.
// Assumes start is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
module cidh_half_bit #(
	parameter CYCLES = 52000
) (
	input  wire pclk,
	input  wire presetn,
	input  wire start,
	input  wire cancel,
	output wire running
);
	reg [16:0] cnt_q;

	// Load on start, count down to zero; cancel ends early
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 17'h00000;
		end else if (start) begin
			cnt_q <= CYCLES[16:0];
		end else if (cancel) begin
			cnt_q <= 17'h00000;
		end else if (cnt_q != 17'h00000) begin
			cnt_q <= cnt_q - 17'h00001;
		end
	end

	assign running = (cnt_q != 17'h00000);
endmodule

// [dv/cidh_top_sva.sv]
// Checker of the caller id host interface outputs.
// Assumes binding into cidh_top, one pclk domain.
`timescale 1ns/1ps
module cidh_top_sva #(
	parameter HALF_BIT_CYC = 52000
) (
	input wire pclk,
	input wire presetn,
	input wire demod_bit,
	input wire demod_bit_mid,
	input wire ring_sense_in,
	input wire ring_hold_rc,
	input wire serial_bit_clock_i,
	input wire serial_bit_clock_o,
	input wire serial_bit_clock_oe_n,
	input wire serial_data,
	input wire byte_ready_n,
	input wire carrier_present_n,
	input wire alert_qualified,
	input wire alert_raw,
	input wire ring_detect_n,
	input wire host_irq_n_oe_n,
	input wire sleep_out,
	input wire demod_select
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Length of a byte ready low spell; too long a spell shows a lost timer
	reg [31:0] low_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_q <= 32'h0;
		else
			low_q <= byte_ready_n ? 32'h0 : low_q + 32'h1;
	end
	// Mode 0 bit taken, then one low clock cycle
	sequence mid_s;
		demod_bit_mid && !carrier_present_n && demod_select
			&& !serial_bit_clock_oe_n && !sleep_out;
	endsequence
	sequence pulse_s;
		!serial_bit_clock_o ##1 serial_bit_clock_o;
	endsequence
	m0_bit_out_a: assert property (
		mid_s |=> (serial_data == $past(demod_bit)) ##0 pulse_s)
		else $error("mode 0 bit or clock pulse wrong");
	m0_ready_a: assert property (
		!byte_ready_n && !serial_bit_clock_oe_n |=> byte_ready_n)
		else $error("mode 0 byte ready longer than one cycle");
	m1_timeout_a: assert property (
		low_q <= HALF_BIT_CYC + 1)
		else $error("byte ready held past half bit");
	m1_release_a: assert property (
		!byte_ready_n && serial_bit_clock_oe_n && $rose(serial_bit_clock_i)
		|=> !byte_ready_n ##[1:4] byte_ready_n)
		else $error("byte ready not released by host clock");
	sleep_idle_a: assert property (
		sleep_out && $past(sleep_out) |-> byte_ready_n && carrier_present_n
		&& !alert_raw && !alert_qualified)
		else $error("outputs active while asleep");
	ring_path_a: assert property (
		(ring_sense_in || !ring_hold_rc) [*3] |-> !ring_detect_n)
		else $error("ring detect missing");
	irq_set_a: assert property (
		!ring_detect_n || !byte_ready_n || alert_qualified |=> !host_irq_n_oe_n)
		else $error("interrupt not pulled low");
	irq_clr_a: assert property (
		ring_detect_n && byte_ready_n && !alert_qualified |=> host_irq_n_oe_n)
		else $error("interrupt held without cause");
	alert_gate_a: assert property (
		demod_select && $past(demod_select) |-> !alert_raw && !alert_qualified)
		else $error("alert while demodulator selected");
endmodule
bind cidh_top cidh_top_sva #(.HALF_BIT_CYC(HALF_BIT_CYC)) u_cidh_top_sva (
	.pclk, .presetn, .demod_bit, .demod_bit_mid, .ring_sense_in,
	.ring_hold_rc, .serial_bit_clock_i, .serial_bit_clock_o,
	.serial_bit_clock_oe_n, .serial_data, .byte_ready_n, .carrier_present_n,
	.alert_qualified, .alert_raw, .ring_detect_n, .host_irq_n_oe_n,
	.sleep_out, .demod_select);

// [dv/cidh_host_model.sv]
// Host side model: clocks a byte out of the serial port in mode 1.
// Assumes the bench resolves the clock pin from the device enable.
`timescale 1ns/1ps
module cidh_host_model (
	input  wire pclk,
	input  wire serial_data,
	output reg  host_clk
);
	// Clock stands low between reads
	initial host_clk = 1'b0;
	// Nine rises, the last must be ignored; gap sets a prompt or slow host
	task automatic read_byte(input int gap, output logic [7:0] b);
		for (int i = 0; i < 9; i++) begin
			repeat (gap) @(posedge pclk);
			host_clk <= 1'b1;
			repeat (6) @(posedge pclk);
			if (i < 8)
				b[i] = serial_data;
			host_clk <= 1'b0;
		end
	endtask
endmodule

// [dv/tb_top.sv]
// Self-checking bench of the caller id host interface logic.
// Assumes 125 MHz pclk and the host model on the bit clock pin.
`timescale 1ns/1ps
module tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, demod_bit = 1'b0, demod_bit_mid = 1'b0;
	logic        demod_start = 1'b0, carrier_det = 1'b0, tone_det = 1'b0;
	logic        tone_guard_met = 1'b0, ring_sense_in = 1'b0, err;
	logic        ring_hold_rc = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [7:0]  got;
	int          failures = 0, cmp_count = 0, n;
	wire  [31:0] prdata;
	wire         pready, pslverr, serial_bit_clock_o, serial_bit_clock_oe_n;
	wire         serial_data, byte_ready_n, carrier_present_n, alert_raw;
	wire         alert_qualified, ring_detect_n, host_irq_n_o, host_clk;
	wire         host_irq_n_oe_n, sleep_out, demod_select;
	// Pin levels; the interrupt line has a pull-up
	wire         serial_bit_clock_i = serial_bit_clock_oe_n ? host_clk
		: serial_bit_clock_o;
	wire         irq_n = host_irq_n_oe_n ? 1'b1 : host_irq_n_o;
	cidh_top #(.HALF_BIT_CYC(40)) u_cidh_top (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.demod_bit, .demod_bit_mid, .demod_start, .carrier_det, .tone_det,
		.tone_guard_met, .ring_sense_in, .ring_hold_rc, .serial_bit_clock_i,
		.serial_bit_clock_o, .serial_bit_clock_oe_n, .serial_data,
		.byte_ready_n, .carrier_present_n, .alert_qualified, .alert_raw,
		.ring_detect_n, .host_irq_n_o, .host_irq_n_oe_n, .sleep_out,
		.demod_select);
	cidh_host_model u_cidh_host_model (.pclk, .serial_data, .host_clk);
	// Clock
	always #4 pclk = ~pclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; waits for pready, takes data at that edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Start bit then eight mid-bit strobes, LSB first on the line
	task automatic send(input logic [7:0] b);
		demod_start <= 1'b1;
		@(posedge pclk);
		demod_start <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			demod_bit <= b[i];
			demod_bit_mid <= 1'b1;
			@(posedge pclk);
			demod_bit_mid <= 1'b0;
			#1;
			if (!serial_bit_clock_oe_n)
				chk({serial_bit_clock_o, serial_data}, {1'b0, b[i]});
			// Last bit returns at once so the ready pulse is not missed
			if (i < 7)
				repeat (3) @(posedge pclk);
		end
	endtask
	task automatic wait_rdy();
		for (n = 0; n < 20 && byte_ready_n !== 1'b0; n++) @(posedge pclk);
		chk(byte_ready_n, 1'b0);
	endtask
	task automatic t_sleep();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		carrier_det <= 1'b1;
		ring_sense_in <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({ring_detect_n, irq_n, carrier_present_n}, 3'h1);
		ring_sense_in <= 1'b0;
		apb(1'b0, 12'h00C, 32'h0);
		chk(err, 1'b1);
		repeat (2) @(posedge pclk);
		chk(irq_n, 1'b1);
	endtask
	task automatic t_mode0();
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h000, 32'h2);
		for (n = 0; n < 100 && carrier_present_n !== 1'b0; n++)
			@(posedge pclk);
		chk(carrier_present_n, 1'b0);
		send(8'hA5);
		wait_rdy();
		@(posedge pclk);
		chk(byte_ready_n, 1'b1);
	endtask
	task automatic t_mode1();
		apb(1'b1, 12'h000, 32'h6);
		send(8'hB4);
		wait_rdy();
		u_cidh_host_model.read_byte(2, got);
		chk(got, 8'hB4);
		chk(serial_data, 1'b1);
		send(8'hC5);
		wait_rdy();
		for (n = 0; n < 60 && byte_ready_n !== 1'b1; n++) @(posedge pclk);
		chk(n >= 38 && n <= 42, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h000000C5);
		// Sleep while awake with carrier present must idle the outputs
		apb(1'b1, 12'h000, 32'h7);
		repeat (2) @(posedge pclk);
		chk({carrier_present_n, sleep_out, demod_select}, 3'h7);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h00000000);
	endtask
	task automatic t_alert();
		apb(1'b1, 12'h000, 32'h0);
		tone_det <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({alert_raw, alert_qualified}, 2'h2);
		tone_guard_met <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({alert_qualified, irq_n}, 2'h2);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[6:5], 2'h3);
		tone_det <= 1'b0;
		tone_guard_met <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(irq_n, 1'b1);
	endtask
	task automatic test_done();
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_sleep();
		t_mode0();
		t_mode1();
		t_alert();
		test_done();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		failures++;
		test_done();
	end
endmodule
